// ==== rtl/scp_card.sv ====
// Summary of operation
// - Socket modes: host ties role pin to A25 or ground
// - Role pin pulled up inside the card
// - Disk mode: grounded is master, open slave
// - D00 even byte LSB, D08 odd byte LSB
// - Disk mode register access: byte on D7-D0
// - Disk mode data transfer: full 16-bit word
// - Memory mode: input acknowledge stays inactive
// - I/O mode: acknowledge only on selected reads
// - Host gates input buffers with acknowledge
// - Request raised when ready to move data
// - Host strobes set each word's direction
// - Request held until acknowledge, reraised if more
// - Request undriven while card not selected
// - Host negates chip selects during DMA acknowledge
`timescale 1ns/100ps
`default_nettype none
`include "scp_cfg.svh"

module scp_card (
    input wire logic core_clk, // Clock
    input wire logic reset, // Sync reset, active high
    input wire scp_pkg::scp_mode_e mode, // Operating mode
    scp_if.card bus, // Card side of the pins
    input wire logic [`SCP_WORD_W-1:0] tx_data, // Word for host to read
    input wire logic tx_valid, // Word offered
    output logic tx_ready, // Room in read buffer
    output logic [`SCP_WORD_W-1:0] rx_data, // Word written by host
    output logic rx_valid, // One-cycle pulse per word
    input wire logic dma_start, // Pulse: arm a DMA run
    input wire logic dma_dir, // 1 host writes, 0 host reads
    input wire logic [`SCP_CNT_W-1:0] dma_words, // Words in the run
    output logic master // Role taken at reset
);

    scp_pkg::scp_card_s q;
    scp_pkg::scp_card_s d;
    logic [`SCP_WORD_W-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic csel_lvl;
    logic sel;
    logic dma_cyc;
    logic reg_cyc;
    logic word;
    logic rd_end;
    logic wr_end;
    logic avail;

    // ==========================================
    // Decode
    // Offset zero of the first select is the word-wide data port
    function automatic logic is_word(input logic [2:0] addr, input logic [1:0] cs_n);
        is_word = (addr == `SCP_DATA_ADDR) && !cs_n[0];
    endfunction

    // Byte registers live at nonzero offsets of the first select
    function automatic logic is_byte(input logic [2:0] addr, input logic [1:0] cs_n);
        is_byte = (addr != `SCP_DATA_ADDR) && !cs_n[0];
    endfunction

    // ==========================================
    // Read buffer: only host reads drain it, so user sees back-pressure
    scp_fifo #(
        .W(`SCP_WORD_W),
        .D(`SCP_FIFO_DEPTH)
    ) u_scp_fifo (
        .core_clk(core_clk),
        .reset(reset),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // ==========================================
    // Outputs come straight from state
    assign bus.card_d_o = q.d_o;
    assign bus.card_d_oe = q.d_oe;
    assign bus.inpack_n = q.inpack_n;
    assign bus.dmarq_o = q.dmarq;
    assign bus.dmarq_oe = q.dmarq_oe;
    assign rx_data = q.rx_data;
    assign rx_valid = q.rx_valid;
    assign master = q.master;

    // ==========================================
    // Next state
    always_comb begin
        d = q;

        csel_lvl = bus.csel_oe ? bus.csel_o : 1'b1;

        if (!q.role_done) begin
            d.master = ~csel_lvl;
            d.role_done = 1'b1;
        end

        // Disk mode: master answers device bit 0, slave bit 1.
        // Socket modes have one card per slot, so always selected.
        sel = (mode != scp_pkg::SCP_IDE) | (q.master ^ q.dev_bit);
        dma_cyc = (mode == scp_pkg::SCP_IDE) & ~bus.dmack_n & sel;
        reg_cyc = ~&bus.cs_n & bus.dmack_n & sel;
        word = dma_cyc | (reg_cyc & is_word(bus.a, bus.cs_n));

        // Trailing edges of the strobes end each access
        rd_end = ~q.iord_n & bus.iord_n;
        wr_end = ~q.iowr_n & bus.iowr_n;
        d.iord_n = bus.iord_n;
        d.iowr_n = bus.iowr_n;

        // Read data driven while the read strobe is low
        d.d_o = '0;
        d.d_oe = `SCP_LANE_NONE;
        if ((dma_cyc | reg_cyc) & ~bus.iord_n) begin
            if (word) begin
                d.d_o = fifo_valid ? fifo_data : '0;
                d.d_oe = `SCP_LANE_BOTH;
            end else begin
                d.d_oe = `SCP_LANE_LOW;
                if (is_byte(bus.a, bus.cs_n)) begin
                    d.d_o = {8'h00, q.tf[bus.a]};
                end
            end
        end

        // Word leaves the buffer only once the read completes
        fifo_pop = rd_end & word & fifo_valid;

        // Host word writes go to the user as one pulse
        d.rx_valid = 1'b0;
        if (wr_end & word) begin
            d.rx_valid = 1'b1;
            d.rx_data = bus.d;
        end

        // Byte writes; the drive select reaches both cards so the
        // unselected one can learn it is being addressed
        if (wr_end & ~&bus.cs_n & bus.dmack_n & is_byte(bus.a, bus.cs_n)) begin
            if (sel) begin
                d.tf[bus.a] = bus.d[7:0];
            end
            if (bus.a == `SCP_DRVHEAD_ADDR) begin
                d.tf[bus.a] = bus.d[7:0];
                d.dev_bit = bus.d[`SCP_DEV_BIT];
            end
        end

        d.inpack_n = ~((mode == scp_pkg::SCP_IO) & reg_cyc & ~bus.iord_n);

        d.dmarq_oe = (mode == scp_pkg::SCP_IDE) & sel;

        // Reads need a buffered word; writes need only a count
        avail = (q.left != '0) & (dma_dir | fifo_valid);

        // ==========================================
        // DMA request handshake
        case (q.dma)
            scp_pkg::SCP_D_IDLE: begin
                d.dmarq = 1'b0;
                if (dma_start && dma_words != '0) begin
                    d.left = dma_words;
                    d.dma = scp_pkg::SCP_D_REQ;
                end
            end
            scp_pkg::SCP_D_REQ: begin
                d.dmarq = q.dmarq | avail;
                if (q.dmarq & dma_cyc) begin
                    d.dma = scp_pkg::SCP_D_ACK;
                end
            end
            scp_pkg::SCP_D_ACK: begin
                if (dma_cyc & (rd_end | wr_end)) begin
                    d.left = `SCP_CNT_W'(q.left - 1'b1);
                end
                d.dmarq = (d.left != '0) & (dma_dir | fifo_valid);
                if (bus.dmack_n) begin
                    d.dma = (d.left != '0) ? scp_pkg::SCP_D_REQ : scp_pkg::SCP_D_IDLE;
                end
            end
            default: begin
                d.dma = scp_pkg::SCP_D_IDLE;
                d.dmarq = 1'b0;
            end
        endcase
    end

    // ==========================================
    // State register; strobes idle high so no false edge at release
    always_ff @(posedge core_clk) begin
        if (reset) begin
            q <= '0;
            q.iord_n <= 1'b1;
            q.iowr_n <= 1'b1;
            q.inpack_n <= 1'b1;
            q.dma <= scp_pkg::SCP_D_IDLE;
            q.tf <= {7{`SCP_REG_RST}};
        end else begin
            q <= d;
        end
    end
endmodule

`default_nettype wire

// ==== rtl/scp_cfg.svh ====
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH

// ==========================================
// Timing
`define SCP_CLK_NS 4
`define SCP_STROBE_NS 70
`define SCP_STROBE_CYC ((`SCP_STROBE_NS + `SCP_CLK_NS - 1) / `SCP_CLK_NS)

// ==========================================
// Widths and depths
`define SCP_WORD_W 16
`define SCP_BYTE_W 8
`define SCP_CNT_W 16
`define SCP_FIFO_DEPTH 4

// ==========================================
// Register file layout
`define SCP_DATA_ADDR 3'h0
`define SCP_DRVHEAD_ADDR 3'h6
`define SCP_DEV_BIT 4
`define SCP_REG_RST 8'h00

// ==========================================
// Byte lane enables
`define SCP_LANE_NONE 2'h0
`define SCP_LANE_LOW 2'h1
`define SCP_LANE_BOTH 2'h3

`endif

// ==== rtl/scp_pkg.sv ====
`include "scp_cfg.svh"

package scp_pkg;

    // ==========================================
    // Operating modes and host command kinds
    typedef enum logic [1:0] {SCP_MEM = 2'h0, SCP_IO = 2'h1, SCP_IDE = 2'h2} scp_mode_e;
    typedef enum logic [1:0] {SCP_K_REG = 2'h0, SCP_K_DATA = 2'h1, SCP_K_DMA = 2'h2} scp_kind_e;

    // ==========================================
    // State machines, one-hot
    typedef enum logic [2:0] {SCP_D_IDLE = 3'h1, SCP_D_REQ = 3'h2, SCP_D_ACK = 3'h4} scp_dma_e;
    typedef enum logic [3:0] {SCP_H_IDLE = 4'h1, SCP_H_SETUP = 4'h2, SCP_H_STROBE = 4'h4,
                              SCP_H_HOLD = 4'h8} scp_hst_e;

    // ==========================================
    // Card state
    typedef struct packed {
        logic master;
        logic role_done;
        logic dev_bit;
        logic [7:1][`SCP_BYTE_W-1:0] tf;
        logic iord_n;
        logic iowr_n;
        logic [`SCP_WORD_W-1:0] d_o;
        logic [1:0] d_oe;
        logic inpack_n;
        logic dmarq;
        logic dmarq_oe;
        scp_dma_e dma;
        logic [`SCP_CNT_W-1:0] left;
        logic rx_valid;
        logic [`SCP_WORD_W-1:0] rx_data;
    } scp_card_s;

    // ==========================================
    // Host state
    typedef struct packed {
        scp_hst_e st;
        logic [7:0] cnt;
        scp_kind_e kind;
        logic wr;
        logic [2:0] a;
        logic [1:0] cs_n;
        logic iord_n;
        logic iowr_n;
        logic dmack_n;
        logic [`SCP_WORD_W-1:0] d_o;
        logic [1:0] d_oe;
        logic csel_o;
        logic csel_oe;
        logic cmd_ready;
        logic rsp_valid;
        logic [`SCP_WORD_W-1:0] rsp_data;
        logic buf_en;
    } scp_host_s;

endpackage

// ==== rtl/scp_if.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "scp_cfg.svh"

interface scp_if;
    logic [2:0] a;
    logic [1:0] cs_n;
    logic iord_n;
    logic iowr_n;
    logic dmack_n;
    logic [`SCP_WORD_W-1:0] host_d_o;
    logic [1:0] host_d_oe;
    logic [`SCP_WORD_W-1:0] card_d_o;
    logic [1:0] card_d_oe;
    logic [`SCP_WORD_W-1:0] d;
    logic csel_o;
    logic csel_oe;
    logic inpack_n;
    logic dmarq_o;
    logic dmarq_oe;
    logic dmarq;

    // ==========================================
    // Data lanes: card wins, then host, idle lane reads low
    genvar i;
    for (i = 0; i < 2; i++) begin : g_lane
        assign d[i*8 +: 8] = card_d_oe[i] ? card_d_o[i*8 +: 8] :
                             host_d_oe[i] ? host_d_o[i*8 +: 8] : 8'h00;
    end

    // Request line reads low while no card drives it
    assign dmarq = dmarq_oe ? dmarq_o : 1'b0;

    modport card (input a, cs_n, iord_n, iowr_n, dmack_n, d, csel_o, csel_oe,
                  output card_d_o, card_d_oe, inpack_n, dmarq_o, dmarq_oe);
    modport host (output a, cs_n, iord_n, iowr_n, dmack_n, host_d_o, host_d_oe, csel_o, csel_oe,
                  input d, inpack_n, dmarq);
endinterface

`default_nettype wire

// ==== rtl/scp_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none

module scp_fifo #(
    parameter int W = 16,
    parameter int D = 4
) (
    input wire logic core_clk, // Clock
    input wire logic reset, // Sync reset
    input wire logic [W-1:0] in_data, // Write word
    input wire logic in_valid, // Write request
    output logic in_ready, // Room left
    output logic [W-1:0] out_data, // Head word
    output logic out_valid, // Head present
    input wire logic out_ready // Head taken
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } scp_fifo_s;

    scp_fifo_s q;
    scp_fifo_s d;
    logic push;
    logic pop;

    // ==========================================
    // Flags straight from the count, so full and empty are exact
    assign in_ready = (q.cnt != CW'(D));
    assign out_valid = (q.cnt != '0);
    assign out_data = q.mem[q.rp];

    // Pointers wrap at depth, which need not be a power of two
    always_comb begin
        d = q;
        push = in_valid & in_ready;
        pop = out_ready & out_valid;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp = (q.wp == AW'(D - 1)) ? '0 : AW'(q.wp + 1'b1);
        end
        if (pop) begin
            d.rp = (q.rp == AW'(D - 1)) ? '0 : AW'(q.rp + 1'b1);
        end
        d.cnt = CW'(q.cnt + CW'(push) - CW'(pop));
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

`default_nettype wire

// ==== rtl/scp_host.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "scp_cfg.svh"

module scp_host (
    input wire logic core_clk, // Clock
    input wire logic reset, // Sync reset, active high
    input wire scp_pkg::scp_mode_e mode, // Operating mode
    input wire logic csel_ground, // Disk mode: ground role pin
    input wire logic a25_tie, // Socket modes: pin follows A25
    input wire logic a25, // Upper address line
    scp_if.host bus, // Host side of the pins
    input wire logic cmd_valid, // Command offered
    output logic cmd_ready, // Command accepted when high
    input wire scp_pkg::scp_kind_e cmd_kind, // Register, data or DMA
    input wire logic cmd_write, // 1 write, 0 read
    input wire logic [2:0] cmd_addr, // Register offset
    input wire logic [`SCP_WORD_W-1:0] cmd_wdata, // Write data
    output logic rsp_valid, // One-cycle read answer
    output logic [`SCP_WORD_W-1:0] rsp_data, // Read data
    output logic buf_en // Input buffer enable
);

    scp_pkg::scp_host_s q;
    scp_pkg::scp_host_s d;

    assign bus.a = q.a;
    assign bus.cs_n = q.cs_n;
    assign bus.iord_n = q.iord_n;
    assign bus.iowr_n = q.iowr_n;
    assign bus.dmack_n = q.dmack_n;
    assign bus.host_d_o = q.d_o;
    assign bus.host_d_oe = q.d_oe;
    assign bus.csel_o = q.csel_o;
    assign bus.csel_oe = q.csel_oe;
    assign cmd_ready = q.cmd_ready;
    assign rsp_valid = q.rsp_valid;
    assign rsp_data = q.rsp_data;
    assign buf_en = q.buf_en;

    // ==========================================
    // Next state
    always_comb begin
        d = q;
        d.rsp_valid = 1'b0;

        if (mode == scp_pkg::SCP_IDE) begin
            d.csel_o = 1'b0;
            d.csel_oe = csel_ground;
        end else begin
            d.csel_o = a25_tie & a25;
            d.csel_oe = 1'b1;
        end

        d.buf_en = (mode == scp_pkg::SCP_IO) & ~bus.inpack_n;

        case (q.st)
            scp_pkg::SCP_H_IDLE: begin
                if (cmd_valid & q.cmd_ready) begin
                    d.cmd_ready = 1'b0;
                    d.kind = cmd_kind;
                    d.wr = cmd_write;
                    d.st = scp_pkg::SCP_H_SETUP;
                    if (cmd_kind != scp_pkg::SCP_K_DMA) begin
                        d.cs_n = 2'h2;
                        d.a = (cmd_kind == scp_pkg::SCP_K_DATA) ? `SCP_DATA_ADDR : cmd_addr;
                    end
                    if (cmd_write) begin
                        d.d_oe = (cmd_kind == scp_pkg::SCP_K_REG) ? `SCP_LANE_LOW : `SCP_LANE_BOTH;
                        d.d_o = (cmd_kind == scp_pkg::SCP_K_REG) ? {8'h00, cmd_wdata[7:0]} : cmd_wdata;
                    end
                end
            end
            scp_pkg::SCP_H_SETUP: begin
                // DMA words wait for the card's request
                if (q.kind != scp_pkg::SCP_K_DMA || bus.dmarq) begin
                    d.dmack_n = (q.kind != scp_pkg::SCP_K_DMA);
                    d.iord_n = q.wr;
                    d.iowr_n = ~q.wr;
                    d.cnt = '0;
                    d.st = scp_pkg::SCP_H_STROBE;
                end
            end
            scp_pkg::SCP_H_STROBE: begin
                d.cnt = 8'(q.cnt + 1'b1);
                if (q.cnt == 8'(`SCP_STROBE_CYC - 1)) begin
                    d.iord_n = 1'b1;
                    d.iowr_n = 1'b1;
                    d.st = scp_pkg::SCP_H_HOLD;
                    if (!q.wr) begin
                        d.rsp_valid = 1'b1;
                        if (mode == scp_pkg::SCP_IO && bus.inpack_n) begin
                            d.rsp_data = '0;
                        end else if (q.kind == scp_pkg::SCP_K_REG) begin
                            d.rsp_data = {8'h00, bus.d[7:0]};
                        end else begin
                            d.rsp_data = bus.d;
                        end
                    end
                end
            end
            scp_pkg::SCP_H_HOLD: begin
                d.cs_n = 2'h3;
                d.dmack_n = 1'b1;
                d.d_oe = `SCP_LANE_NONE;
                d.cmd_ready = 1'b1;
                d.st = scp_pkg::SCP_H_IDLE;
            end
            default: begin
                d.st = scp_pkg::SCP_H_IDLE;
            end
        endcase
    end

    // ==========================================
    // State register; all strobes and selects negated in reset.
    // The role strap is a wire, not a bus cycle, so it keeps its level through
    // reset; otherwise the card would latch an undriven pin at release.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            q <= '0;
            q.st <= scp_pkg::SCP_H_IDLE;
            q.cs_n <= 2'h3;
            q.iord_n <= 1'b1;
            q.iowr_n <= 1'b1;
            q.dmack_n <= 1'b1;
            q.cmd_ready <= 1'b1;
            q.csel_o <= d.csel_o;
            q.csel_oe <= d.csel_oe;
        end else begin
            q <= d;
        end
    end
endmodule

`default_nettype wire

// ==== tb/scp_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "scp_cfg.svh"

module scp_sva (
    input wire logic core_clk, // Clock
    input wire logic reset, // Sync reset
    input wire scp_pkg::scp_mode_e mode, // Operating mode
    input wire logic [2:0] a, // Register offset
    input wire logic [1:0] cs_n, // Selects
    input wire logic iord_n, // Read strobe
    input wire logic dmack_n, // DMA acknowledge
    input wire logic [1:0] host_d_oe, // Host lanes
    input wire logic [1:0] card_d_oe, // Card lanes
    input wire logic inpack_n, // Input acknowledge
    input wire logic dmarq, // Resolved request
    input wire logic dmarq_oe // Request enable
);
    // ==========================================
    // Pin relations, all in the one clock domain
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    // Acknowledge pin in the socket modes
    AST_INPACK_MEM: assert property (mode == scp_pkg::SCP_MEM |-> inpack_n)
        else $error("input ack low in memory mode");
    AST_INPACK_CAUSE: assert property (!inpack_n |-> mode == scp_pkg::SCP_IO && (!$past(iord_n) || !$past(iord_n, 2)))
        else $error("input ack without a read strobe");
    AST_INPACK_END: assert property ($rose(iord_n) |-> ##[1:2] inpack_n)
        else $error("input ack outlives the read");

    // Request handshake
    AST_DMARQ_HOLD: assert property (dmarq && dmack_n |=> dmarq)
        else $error("request dropped before acknowledge");
    AST_DMARQ_SOCKET: assert property (mode != scp_pkg::SCP_IDE |-> !dmarq_oe)
        else $error("request driven outside disk mode");

    // Lane use in disk mode; reg and data offsets differ by lane count
    AST_CARD_REG_BYTE: assert property (mode == scp_pkg::SCP_IDE && cs_n == 2'h2 && a != 3'h0
        && card_d_oe != 2'h0 |-> card_d_oe == `SCP_LANE_LOW)
        else $error("card register read not a low byte");
    AST_CARD_WORD: assert property ((mode == scp_pkg::SCP_IDE && cs_n == 2'h2 && a == 3'h0 || !dmack_n)
        && card_d_oe != 2'h0 |-> card_d_oe == `SCP_LANE_BOTH)
        else $error("card data transfer not a full word");
    AST_HOST_REG_BYTE: assert property (mode == scp_pkg::SCP_IDE && cs_n == 2'h2 && a != 3'h0
        && host_d_oe != 2'h0 |-> host_d_oe == `SCP_LANE_LOW)
        else $error("host register write not a low byte");
    AST_HOST_DMA: assert property (!dmack_n |-> cs_n == 2'h3 && host_d_oe != `SCP_LANE_LOW)
        else $error("selects or byte lane during DMA acknowledge");
endmodule

`default_nettype wire

// ==== tb/scp_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "scp_cfg.svh"

module scp_tb;
    // ==========================================
    // Stimulus and observed signals
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    scp_pkg::scp_mode_e mode = scp_pkg::SCP_IDE;
    scp_pkg::scp_kind_e cmd_kind = scp_pkg::SCP_K_REG;
    logic csel_ground = 1'b1, a25_tie = 1'b1, a25 = 1'b1;
    logic cmd_valid = 1'b0, cmd_write = 1'b0, tx_valid = 1'b0, dma_start = 1'b0, dma_dir = 1'b0;
    logic [2:0] cmd_addr = 3'h0;
    logic [15:0] cmd_wdata = 16'h0000, tx_data = 16'h0000, dma_words = 16'h0000;
    logic cmd_ready, rsp_valid, buf_en, tx_ready, rx_valid, master, seen_ack, seen_buf;
    logic [15:0] rsp_data, rx_data, rd, rx_last, d_last;
    int fail_count = 0;
    int total_checks = 0;

    always #2 core_clk = ~core_clk;

    scp_if bus ();
    scp_card u_scp_card (.core_clk, .reset, .mode, .bus(bus.card), .tx_data, .tx_valid, .tx_ready,
        .rx_data, .rx_valid, .dma_start, .dma_dir, .dma_words, .master);
    scp_host u_scp_host (.core_clk, .reset, .mode, .csel_ground, .a25_tie, .a25, .bus(bus.host),
        .cmd_valid, .cmd_ready, .cmd_kind, .cmd_write, .cmd_addr, .cmd_wdata, .rsp_valid, .rsp_data, .buf_en);
    scp_sva u_scp_sva (.core_clk, .reset, .mode, .a(bus.a), .cs_n(bus.cs_n), .iord_n(bus.iord_n),
        .dmack_n(bus.dmack_n), .host_d_oe(bus.host_d_oe), .card_d_oe(bus.card_d_oe),
        .inpack_n(bus.inpack_n), .dmarq(bus.dmarq), .dmarq_oe(bus.dmarq_oe));

    // Watch the pins: full-word bus value, acknowledge and buffer enable seen
    always @(posedge core_clk) begin
        if (rx_valid === 1'b1) rx_last <= rx_data;
        if (bus.host_d_oe === 2'h3 || bus.card_d_oe === 2'h3) d_last <= bus.d;
        if (bus.inpack_n === 1'b0) seen_ack <= 1'b1;
        if (buf_en === 1'b1) seen_buf <= 1'b1;
    end

    // ==========================================
    // Shared tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic stall(input string what);
        fail_count++;
        $display("MISMATCH %s expected done seen timeout", what);
        results();
    endtask

    // Inputs always move 1 ns after the rising edge
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask

    task automatic done(input string t);
        $display("test %s finished, mismatches %0d", t, fail_count);
    endtask

    task automatic rst(input scp_pkg::scp_mode_e m, input logic g);
        mode = m;
        csel_ground = g;
        reset = 1'b1;
        repeat (3) tick();
        reset = 1'b0;
        repeat (2) tick();
        seen_ack = 1'b0;
        seen_buf = 1'b0;
    endtask

    // Host command: offered for one cycle once ready, then wait for answer or ready
    task automatic cmd(input scp_pkg::scp_kind_e k, input logic w, input logic [2:0] ad, input logic [15:0] wd);
        int n;
        for (n = 0; n < 100 && cmd_ready !== 1'b1; n++) tick();
        if (n == 100) stall("cmd_ready");
        cmd_kind = k;
        cmd_write = w;
        cmd_addr = ad;
        cmd_wdata = wd;
        cmd_valid = 1'b1;
        tick();
        cmd_valid = 1'b0;
        for (n = 0; n < 400 && (w ? cmd_ready : rsp_valid) !== 1'b1; n++) tick();
        if (n == 400) stall("answer");
        rd = rsp_data;
        repeat (2) tick();
    endtask

    task automatic push(input logic [15:0] w);
        int n;
        tx_data = w;
        tx_valid = 1'b1;
        for (n = 0; n < 50 && tx_ready !== 1'b1; n++) tick();
        if (n == 50) stall("tx_ready");
        tick();
        tx_valid = 1'b0;
        tick();
    endtask

    task automatic arm(input logic dir, input logic [15:0] words);
        dma_dir = dir;
        dma_words = words;
        dma_start = 1'b1;
        tick();
        dma_start = 1'b0;
        repeat (2) tick();
    endtask

    // Bounded run length
    initial begin
        repeat (20000) @(posedge core_clk);
        stall("run");
    end

    // ==========================================
    // Test sequence
    initial begin
        rst(scp_pkg::SCP_IDE, 1'b1);
        chk("master", 16'h1, 16'(master));
        cmd(scp_pkg::SCP_K_REG, 1'b1, 3'h2, 16'hab5a);
        cmd(scp_pkg::SCP_K_REG, 1'b0, 3'h2, 16'h0000);
        chk("reg byte", 16'h005a, rd);
        for (int i = 0; i < 4; i++) push(16'h1230 + 16'(i));
        chk("tx_ready full", 16'h0, 16'(tx_ready));
        for (int i = 0; i < 4; i++) begin
            cmd(scp_pkg::SCP_K_DATA, 1'b0, 3'h0, 16'h0000);
            chk("data read", 16'h1230 + 16'(i), rd);
            chk("bus word", 16'h1230 + 16'(i), d_last);
        end
        cmd(scp_pkg::SCP_K_DATA, 1'b0, 3'h0, 16'h0000);
        chk("empty read", 16'h0000, rd);
        cmd(scp_pkg::SCP_K_DATA, 1'b1, 3'h0, 16'hbeef);
        chk("rx word", 16'hbeef, rx_last);
        chk("bus word", 16'hbeef, d_last);
        done("disk_pio");
        push(16'h5a01);
        push(16'h5a02);
        arm(1'b0, 16'h0002);
        chk("dmarq", 16'h1, 16'(bus.dmarq));
        for (int i = 0; i < 2; i++) begin
            cmd(scp_pkg::SCP_K_DMA, 1'b0, 3'h0, 16'h0000);
            chk("dma read", 16'h5a01 + 16'(i), rd);
        end
        arm(1'b1, 16'h0001);
        cmd(scp_pkg::SCP_K_DMA, 1'b1, 3'h0, 16'h0f0f);
        chk("dma write", 16'h0f0f, rx_last);
        chk("dmarq end", 16'h0, 16'(bus.dmarq));
        done("dma");
        rst(scp_pkg::SCP_IDE, 1'b0);
        chk("master", 16'h0, 16'(master));
        csel_ground = 1'b1;
        repeat (3) tick();
        chk("master fixed", 16'h0, 16'(master));
        arm(1'b1, 16'h0001);
        chk("dmarq_oe", 16'h0, 16'(bus.dmarq_oe));
        cmd(scp_pkg::SCP_K_REG, 1'b1, 3'h6, 16'h0010);
        arm(1'b1, 16'h0001);
        chk("dmarq_oe", 16'h1, 16'(bus.dmarq_oe));
        chk("dmarq", 16'h1, 16'(bus.dmarq));
        cmd(scp_pkg::SCP_K_DMA, 1'b1, 3'h0, 16'h7e81);
        chk("dma write", 16'h7e81, rx_last);
        done("slave");
        rst(scp_pkg::SCP_IO, 1'b1);
        chk("role pin", 16'h3, {14'h0, bus.csel_oe, bus.csel_o});
        a25 = 1'b0;
        repeat (2) tick();
        chk("role pin", 16'h2, {14'h0, bus.csel_oe, bus.csel_o});
        push(16'h9c3e);
        cmd(scp_pkg::SCP_K_DATA, 1'b0, 3'h0, 16'h0000);
        chk("io read", 16'h9c3e, rd);
        chk("ack seen", 16'h1, 16'(seen_ack));
        chk("buffer enable", 16'h1, 16'(seen_buf));
        seen_ack = 1'b0;
        cmd(scp_pkg::SCP_K_REG, 1'b1, 3'h2, 16'h0011);
        chk("ack on write", 16'h0, 16'(seen_ack));
        done("io");
        rst(scp_pkg::SCP_MEM, 1'b1);
        push(16'h4444);
        cmd(scp_pkg::SCP_K_DATA, 1'b0, 3'h0, 16'h0000);
        chk("mem read", 16'h4444, rd);
        chk("ack in memory mode", 16'h0, 16'(seen_ack));
        done("mem");
        results();
    end
endmodule

`default_nettype wire
